// *** verilog/trig_seq_ctrl.sv ***
/*
  control/status logic of a trigger sequencer behind an avalon-mm slave.
  assumes one system clock, synchronous reset, and an idle request and
  external wait inputs from other clock domains.
*/
// Summary of operation
// RULE_01 - enable bit runs module, else inactive
// RULE_02 - halt-in-idle suspends sequencer during idle
// RULE_03 - toggle mode inverts trigger output per emit
// RULE_04 - pulse mode emits one programmed-width pulse
// RULE_05 - soft trigger write one triggers, zero ignored
// RULE_06 - soft trigger only for wait-soft-trigger step
// RULE_07 - single-step bit enables single-step mode
// RULE_08 - visibility one reads live counters
// RULE_09 - visibility zero reads written limits
// RULE_10 - run bit executes commands, clear stops
// RULE_11 - watchdog expiry sets timeout flag
// RULE_12 - wait mode affects only input wait commands
// RULE_13 - control bits and timeout reset to zero
// RULE_14 - unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "seq_ctrl_map.svh"
module trig_seq_ctrl
  import seq_ctrl_pkg::*;
#(
  parameter int N_OUT = 4,
  parameter int N_IN = 4,
  parameter int CMD_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // device state and inputs
  input wire logic idle_req_i,
  input wire logic [N_IN-1:0] wait_input_i,
  // trigger outputs and interrupt
  output logic [N_OUT-1:0] trigger_output_o,
  output logic irq_o
);
  localparam int AW = $clog2(CMD_DEPTH);

  // control/status
  logic [15:0] cst_q;
  logic wdto_q;
  logic [15:0] step_lim_q, loop_lim_q, timer_lim_q, wdog_lim_q;
  logic [3:0] pulse_width_q;
  logic [2:0] irq_stat_q, irq_mask_q;
  seq_cmd_s cmd_mem [CMD_DEPTH];
  logic [AW-1:0] pc_q;
  logic soft_pend_q;
  seq_live_s live_q;
  seq_cfg_s cfg;

  // synchronisers
  logic idle_meta_q, idle_q;
  logic [N_IN-1:0] in_meta_q, in_q;

  // bus
  logic rd_ack_q, wr_ack_q;
  logic wr_en, rd_en;
  logic [15:0] wdata16;

  // sequencer
  typedef enum logic [1:0] {S_STOP, S_FETCH, S_EXEC} seq_state_e;
  seq_state_e state_q;
  seq_cmd_s cur;
  logic active, emit, step_done, waiting, wd_expire, step_ok, step_fin;
  logic [N_OUT-1:0] emit_vec;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [3:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign cfg.enable = cst_q[`BIT_ENABLE];
  assign cfg.halt_in_idle = cst_q[`BIT_HALT_IDLE];
  assign cfg.output_toggle_select = cst_q[`BIT_TOGGLE];
  assign cfg.single_step_enable = cst_q[`BIT_SSTEP];
  assign cfg.counter_visibility = cst_q[`BIT_VIS];
  assign cfg.sequencer_run = cst_q[`BIT_RUN];
  assign cfg.input_wait_mode = cst_q[`BIT_WAIT_HI:`BIT_WAIT_LO];

  // one wait state per access keeps read data registered; a write
  // lands only on the edge that sees waitrequest low
  assign wr_en = avs_write_i && wr_ack_q;
  assign rd_en = avs_read_i && !rd_ack_q;
  assign avs_waitrequest_o = (avs_read_i && !rd_ack_q) || (avs_write_i && !wr_ack_q);
  assign wdata16 = avs_writedata_i[15:0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idle_meta_q <= 1'b0;
      idle_q <= 1'b0;
      in_meta_q <= '0;
      in_q <= '0;
    end else begin
      idle_meta_q <= idle_req_i;
      idle_q <= idle_meta_q;
      in_meta_q <= wait_input_i;
      in_q <= in_meta_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_ack_q <= 1'b0;
      wr_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_en;
      wr_ack_q <= avs_write_i && !wr_ack_q;
    end
  end

  // control/status writes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cst_q <= `CST_RESET; // [RULE_13]
    end else begin
      if (wr_en && avs_address_i == `CST_OFFSET) begin
        // soft trigger bit never stored; unimplemented bits dropped
        cst_q <= merge16(cst_q, wdata16, avs_byteenable_i) & `CST_WRITE_MASK
                 & ~(16'h0001 << `BIT_SOFT_TRIG); // [RULE_14]
      end else if (step_fin && cfg.single_step_enable) begin
        // software write wins over the step's own stop
        cst_q[`BIT_RUN] <= 1'b0; // [RULE_07]
      end
    end
  end

  // limits, pulse width, interrupt mask
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      step_lim_q <= `LIM_RESET;
      loop_lim_q <= `LIM_RESET;
      timer_lim_q <= `LIM_RESET;
      wdog_lim_q <= `WDOG_LIM_RESET;
      pulse_width_q <= `PULSE_WIDTH_RESET;
      irq_mask_q <= '0;
    end else if (wr_en) begin
      case (avs_address_i)
        `STEP_LIM_OFFSET: step_lim_q <= merge16(step_lim_q, wdata16, avs_byteenable_i);
        `LOOP_LIM_OFFSET: loop_lim_q <= merge16(loop_lim_q, wdata16, avs_byteenable_i);
        `TIMER_LIM_OFFSET: timer_lim_q <= merge16(timer_lim_q, wdata16, avs_byteenable_i);
        `WDOG_LIM_OFFSET: wdog_lim_q <= merge16(wdog_lim_q, wdata16, avs_byteenable_i);
        `PULSE_WIDTH_OFFSET: begin
          if (avs_byteenable_i[0]) begin
            pulse_width_q <= wdata16[3:0];
          end
        end
        `IRQ_MASK_OFFSET: begin
          if (avs_byteenable_i[0]) begin
            irq_mask_q <= wdata16[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // command slots: word at CMD_OFFSET, bits 11:8 slot index, 4:0 command
  // unwritten slots run as no-ops, never as unknown commands
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < CMD_DEPTH; i++) begin
        cmd_mem[i] <= '{op: OP_NOP, sel: 2'b00};
      end
    end else if (wr_en && avs_address_i == `CMD_OFFSET && avs_byteenable_i[1:0] == 2'b11) begin
      cmd_mem[wdata16[8+AW-1:8]] <= seq_cmd_s'(wdata16[4:0]);
    end
  end

  // soft trigger pending: set wins over consume
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !cfg.enable) begin
      soft_pend_q <= 1'b0;
    end else if (wr_en && avs_address_i == `CST_OFFSET && avs_byteenable_i[1]
                 && wdata16[`BIT_SOFT_TRIG]) begin
      soft_pend_q <= 1'b1; // [RULE_05]
    end else if (active && state_q == S_EXEC && cur.op == OP_WAIT_SOFT_TRIGGER) begin
      soft_pend_q <= 1'b0; // [RULE_06]
    end
  end

  // module runs when enabled and not halted by idle
  assign active = cfg.enable && !(cfg.halt_in_idle && idle_q); // [RULE_01] [RULE_02]
  assign cur = cmd_mem[pc_q];
  // single-step: run bit is cleared after each step
  assign step_ok = cfg.sequencer_run; // [RULE_10]

  always_comb begin
    step_done = 1'b0;
    case (cur.op)
      OP_EMIT_TRIGGER: step_done = 1'b1;
      // wait mode 00 waits for the level, other modes need it held
      OP_WAIT_INPUT_HIGH: step_done = in_q[cur.sel] && (cfg.input_wait_mode == 2'b00
                                      || live_q.timer >= timer_lim_q); // [RULE_12]
      OP_WAIT_INPUT_LOW: step_done = !in_q[cur.sel] && (cfg.input_wait_mode == 2'b00
                                      || live_q.timer >= timer_lim_q); // [RULE_12]
      OP_WAIT_SOFT_TRIGGER: step_done = soft_pend_q; // [RULE_06]
      OP_DELAY: step_done = live_q.step_delay >= step_lim_q;
      default: step_done = 1'b1;
    endcase
  end

  assign waiting = active && state_q == S_EXEC && !step_done;
  assign step_fin = active && state_q == S_EXEC && step_done;
  assign emit = active && state_q == S_EXEC && cur.op == OP_EMIT_TRIGGER;
  assign emit_vec = emit ? (N_OUT'(1) << cur.sel) : '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= S_STOP;
      pc_q <= '0;
    end else if (!cfg.enable || wd_expire) begin
      state_q <= S_STOP;
      pc_q <= '0;
    end else if (active) begin
      case (state_q)
        S_STOP: if (step_ok) state_q <= S_FETCH;
        S_FETCH: state_q <= S_EXEC;
        S_EXEC: begin
          if (step_done) begin
            pc_q <= pc_q + 1'b1;
            state_q <= (step_ok && !cfg.single_step_enable) ? S_FETCH : S_STOP; // [RULE_07]
          end else if (!step_ok) begin
            state_q <= S_STOP; // [RULE_10]
          end
        end
        default: state_q <= S_STOP;
      endcase
    end
  end

  // live counters
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !cfg.enable) begin
      live_q <= '0;
    end else if (active && state_q == S_EXEC) begin
      live_q.step_delay <= step_done ? 16'h0000 : live_q.step_delay + 16'h0001;
      live_q.timer <= (cur.op == OP_WAIT_INPUT_HIGH ? in_q[cur.sel] : !in_q[cur.sel])
                      ? live_q.timer + 16'h0001 : 16'h0000;
      if (step_done && pc_q == AW'(CMD_DEPTH - 1)) begin
        live_q.loop_count <= live_q.loop_count + 16'h0001;
      end
    end
  end

  // timeout flag and interrupt status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wdto_q <= 1'b0; // [RULE_13]
    end else if (wd_expire) begin
      wdto_q <= 1'b1; // [RULE_11]
    end else if (wr_en && avs_address_i == `CST_OFFSET && avs_byteenable_i[0]
                 && !wdata16[`BIT_WDTO]) begin
      wdto_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      // events win over the clearing read
      irq_stat_q <= ((rd_en && avs_address_i == `IRQ_STAT_OFFSET) ? 3'b000 : irq_stat_q)
                    | {emit, active && state_q == S_EXEC && step_done, wd_expire};
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // read data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (rd_en) begin
      case (avs_address_i)
        `CST_OFFSET: avs_readdata_o <= {16'h0000, cst_q | (16'(wdto_q) << `BIT_WDTO)}; // [RULE_14]
        `STEP_LIM_OFFSET: avs_readdata_o <= {16'h0000,
          cfg.counter_visibility ? live_q.step_delay : step_lim_q}; // [RULE_08] [RULE_09]
        `LOOP_LIM_OFFSET: avs_readdata_o <= {16'h0000,
          cfg.counter_visibility ? live_q.loop_count : loop_lim_q}; // [RULE_08] [RULE_09]
        `TIMER_LIM_OFFSET: avs_readdata_o <= {16'h0000,
          cfg.counter_visibility ? live_q.timer : timer_lim_q}; // [RULE_08] [RULE_09]
        `IRQ_STAT_OFFSET: avs_readdata_o <= {29'h0000_0000, irq_stat_q};
        `IRQ_MASK_OFFSET: avs_readdata_o <= {29'h0000_0000, irq_mask_q};
        `PULSE_WIDTH_OFFSET: avs_readdata_o <= {28'h000_0000, pulse_width_q};
        `WDOG_LIM_OFFSET: avs_readdata_o <= {16'h0000, wdog_lim_q};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  wdog_timer #(.W(16)) u_wdog (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .waiting_i(waiting),
    .limit_i(wdog_lim_q),
    .expire_o(wd_expire)
  );

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      trig_out_gen #(.PW_BITS(4)) u_out (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .enable_i(cfg.enable),
        .emit_i(emit_vec[g]),
        .toggle_mode_i(cfg.output_toggle_select),
        .width_i(pulse_width_q),
        .trigger_output_o(trigger_output_o[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// *** common/seq_ctrl_map.svh ***
/*
  register offsets, field positions, write mask and reset values of the
  trigger sequencer control block. assumes byte addressing on a 32-bit bus.
*/
`ifndef SEQ_CTRL_MAP_SVH
`define SEQ_CTRL_MAP_SVH

`define CST_OFFSET 8'h00
`define STEP_LIM_OFFSET 8'h04
`define LOOP_LIM_OFFSET 8'h08
`define TIMER_LIM_OFFSET 8'h0C
`define CMD_OFFSET 8'h10
`define IRQ_STAT_OFFSET 8'h14
`define IRQ_MASK_OFFSET 8'h18
`define PULSE_WIDTH_OFFSET 8'h1C
`define WDOG_LIM_OFFSET 8'h20

`define BIT_ENABLE 15
`define BIT_HALT_IDLE 13
`define BIT_TOGGLE 12
`define BIT_SOFT_TRIG 10
`define BIT_SSTEP 9
`define BIT_VIS 8
`define BIT_RUN 7
`define BIT_WDTO 6
`define BIT_WAIT_HI 1
`define BIT_WAIT_LO 0
`define CST_WRITE_MASK 16'hB783

`define CST_RESET 16'h0000
`define LIM_RESET 16'h0000
`define PULSE_WIDTH_RESET 4'h0
`define WDOG_LIM_RESET 16'h0000

`define IRQ_BIT_WDTO 0
`define IRQ_BIT_STEP 1
`define IRQ_BIT_TRIG 2

`endif

// *** common/seq_ctrl_pkg.sv ***
/*
  types of the trigger sequencer control block.
  assumes seq_ctrl_map.svh for numeric constants.
*/
package seq_ctrl_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_EMIT_TRIGGER,
    OP_WAIT_INPUT_HIGH,
    OP_WAIT_INPUT_LOW,
    OP_WAIT_SOFT_TRIGGER,
    OP_DELAY
  } seq_op_e;

  typedef struct packed {
    seq_op_e op;
    logic [1:0] sel;
  } seq_cmd_s;

  typedef struct packed {
    logic enable;
    logic halt_in_idle;
    logic output_toggle_select;
    logic single_step_enable;
    logic counter_visibility;
    logic sequencer_run;
    logic [1:0] input_wait_mode;
  } seq_cfg_s;

  typedef struct packed {
    logic [15:0] step_delay;
    logic [15:0] loop_count;
    logic [15:0] timer;
  } seq_live_s;

endpackage

// *** verilog/trig_out_gen.sv ***
/*
  one trigger output: toggles or emits a pulse of programmed width.
  assumes a one-cycle emit strobe on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_out_gen
  import seq_ctrl_pkg::*;
#(
  parameter int PW_BITS = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  input wire logic emit_i,
  input wire logic toggle_mode_i,
  input wire logic [PW_BITS-1:0] width_i,
  // output
  output logic trigger_output_o
);
  logic [PW_BITS:0] pulse_cnt_q;
  logic level_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !enable_i) begin
      level_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (emit_i && toggle_mode_i) begin
      level_q <= ~level_q; // [RULE_03]
    end else if (emit_i) begin
      level_q <= 1'b1; // [RULE_04]
      pulse_cnt_q <= {1'b0, width_i};
    end else if (!toggle_mode_i && level_q) begin
      // width field n gives n+1 cycles high
      if (pulse_cnt_q == '0) begin
        level_q <= 1'b0; // [RULE_04]
      end else begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  assign trigger_output_o = level_q;
endmodule
`default_nettype wire

// *** verilog/wdog_timer.sv ***
/*
  sequencer watchdog: counts while a command waits, fires once on expiry.
  assumes a limit of zero disables it.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic waiting_i,
  input wire logic [W-1:0] limit_i,
  // event
  output logic expire_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !waiting_i) begin
      cnt_q <= '0;
    end else if (limit_i != '0 && cnt_q != limit_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= waiting_i && limit_i != '0 && cnt_q == limit_i - 1'b1; // [RULE_11]
    end
  end
endmodule
`default_nettype wire

// *** tb/trig_seq_ctrl_checker.sv ***
/* port checks on trig_seq_ctrl: bus wait states, read data, reset, enable.
   assumes a master that holds each request until waitrequest is low. */
`timescale 1ns/1ps
`default_nettype none
`include "seq_ctrl_map.svh"
module trig_seq_ctrl_checker #(
  parameter int N_OUT = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // outputs
  input wire logic [N_OUT-1:0] trigger_output_o,
  input wire logic irq_o
);
  logic acc;
  logic rd_done;
  logic en_q;
  assign acc = avs_read_i | avs_write_i;
  assign rd_done = avs_read_i & ~avs_waitrequest_o;
  // mirror of the enable bit; the write lands at the accepting edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == `CST_OFFSET
                 && avs_byteenable_i[1]) begin
      en_q <= avs_writedata_i[`BIT_ENABLE];
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_wait_first: assert property (acc && !$past(acc) |-> avs_waitrequest_o)
    else $error("no wait state on new access");
  a_wait_one: assert property (acc && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait state longer than one cycle");
  a_idle_nowait: assert property (!acc |-> !avs_waitrequest_o)
    else $error("waitrequest high while idle");
  a_reset_clear: assert property ($past(rst_i) |-> trigger_output_o == '0 && !irq_o)
    else $error("outputs not clear after reset");
  a_cst_unimpl: assert property (rd_done && avs_address_i == `CST_OFFSET
    |-> (avs_readdata_o & 32'hFFFF_4C3C) == 32'h0000_0000)
    else $error("unused status bits read nonzero");
  a_unmapped_zero: assert property (rd_done && avs_address_i > 8'h20
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read nonzero");
  a_read_hold: assert property (!(avs_read_i && avs_waitrequest_o)
    |=> $stable(avs_readdata_o))
    else $error("read data moved between reads");
  // two cycles of grace let a pulse in flight be cut off
  a_off_quiet: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
    |-> $stable(trigger_output_o))
    else $error("trigger output moved while disabled");
  c_cst_write: cover property (avs_write_i && avs_address_i == `CST_OFFSET);
  c_read_done: cover property (rd_done);
  c_trig_rise: cover property ($rose(trigger_output_o[0]));
  c_irq_rise: cover property ($rose(irq_o));
endmodule
bind trig_seq_ctrl trig_seq_ctrl_checker #(.N_OUT(N_OUT)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .trigger_output_o(trigger_output_o),
  .irq_o(irq_o));
`default_nettype wire

// *** tb/trig_peer_model.sv ***
/* peer logic fed by the trigger outputs: rises and pulse width of output 0,
   and a flag for any movement on the others. assumes one system clock. */
`timescale 1ns/1ps
`default_nettype none
module trig_peer_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // trigger outputs of the block
  input wire logic [3:0] trig_i,
  // observations
  output logic [7:0] rises_o,
  output logic [7:0] width_o,
  output logic others_o
);
  logic [3:0] prev_q;
  logic [7:0] high_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev_q <= 4'h0;
      high_q <= 8'h00;
      rises_o <= 8'h00;
      width_o <= 8'h00;
      others_o <= 1'b0;
    end else begin
      prev_q <= trig_i;
      high_q <= trig_i[0] ? high_q + 8'h01 : 8'h00;
      if (trig_i[0] && !prev_q[0]) rises_o <= rises_o + 8'h01;
      if (!trig_i[0] && prev_q[0]) width_o <= high_q;
      if (trig_i[3:1] != prev_q[3:1]) others_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_trigger_sequencer_control.sv ***
/* bench for trig_seq_ctrl: registers, trigger modes, soft trigger, watchdog.
   assumes the peer model on the outputs and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "seq_ctrl_map.svh"
module test_trigger_sequencer_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic idle = 1'b0;
  logic [3:0] win = 4'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [3:0] trig;
  logic irq;
  logic [7:0] rises;
  logic [7:0] width;
  logic others;
  logic [31:0] got;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  trig_seq_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .idle_req_i(idle), .wait_input_i(win), .trigger_output_o(trig), .irq_o(irq));
  trig_peer_model u_peer (.sys_clk_i(clk), .rst_i(rst), .trig_i(trig),
    .rises_o(rises), .width_o(width), .others_o(others));
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    wait_n(5);
    rst <= 1'b0;
  endtask
  // one access; held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= {16'h0000, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task t_regs;
    logic [7:0] offs [8];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20};
    for (int i = 0; i < 8; i++) begin
      bus(0, offs[i], 16'h0000);
      check(got, 32'h0000_0000);
    end
    bus(1, `CST_OFFSET, 16'hFFFF);
    bus(0, `CST_OFFSET, 16'h0000);
    check(got, 32'h0000_B383);
    bus(1, 8'h24, 16'hFFFF);
    bus(0, 8'h24, 16'h0000);
    check(got, 32'h0000_0000);
    bus(1, `STEP_LIM_OFFSET, 16'h1234);
    bus(1, `CST_OFFSET, 16'h0000);
    bus(0, `STEP_LIM_OFFSET, 16'h0000);
    check(got, 32'h0000_1234);
    bus(1, `CST_OFFSET, 16'h8100);
    bus(0, `STEP_LIM_OFFSET, 16'h0000);
    check(got, 32'h0000_0000);
  endtask
  task t_toggle;
    do_reset();
    bus(1, `CMD_OFFSET, 16'h0004);
    bus(1, `IRQ_MASK_OFFSET, 16'h0004);
    bus(1, `CST_OFFSET, 16'h9280);
    wait_n(30);
    check(trig[0], 1'b1);
    check(rises, 8'h01);
    check(others, 1'b0);
    check(irq, 1'b1);
    bus(0, `IRQ_STAT_OFFSET, 16'h0000);
    check(got, 32'h0000_0006);
    wait_n(2);
    check(irq, 1'b0);
  endtask
  task t_pulse;
    do_reset();
    bus(1, `PULSE_WIDTH_OFFSET, 16'h0003);
    bus(1, `CMD_OFFSET, 16'h0004);
    bus(1, `CST_OFFSET, 16'h8280);
    wait_n(30);
    check(rises, 8'h01);
    check(width, 8'h04);
    check(irq, 1'b0);
    do_reset();
    bus(1, `CMD_OFFSET, 16'h0004);
    bus(1, `CST_OFFSET, 16'h1280);
    wait_n(40);
    check(rises, 8'h00);
  endtask
  task t_soft;
    do_reset();
    bus(1, `CMD_OFFSET, 16'h0010);
    bus(1, `CMD_OFFSET, 16'h0104);
    bus(1, `CST_OFFSET, 16'h8080);
    wait_n(30);
    bus(1, `CST_OFFSET, 16'h8080);
    wait_n(30);
    check(rises, 8'h00);
    bus(1, `CST_OFFSET, 16'h8480);
    wait_n(60);
    check(rises, 8'h01);
  endtask
  task t_wait_idle;
    do_reset();
    bus(1, `CMD_OFFSET, 16'h0008);
    bus(1, `CMD_OFFSET, 16'h0104);
    bus(1, `CST_OFFSET, 16'h8080);
    wait_n(30);
    check(rises, 8'h00);
    win <= 4'h1;
    wait_n(60);
    check(rises != 8'h00, 1'b1);
    bus(1, `CST_OFFSET, 16'h8000);
    wait_n(4);
    got = rises;
    wait_n(60);
    check(rises, got);
    do_reset();
    idle <= 1'b1;
    bus(1, `CMD_OFFSET, 16'h0004);
    bus(1, `CST_OFFSET, 16'hA083);
    wait_n(60);
    check(rises, 8'h00);
    idle <= 1'b0;
    wait_n(60);
    check(rises != 8'h00, 1'b1);
  endtask
  task t_wdog;
    do_reset();
    win <= 4'h0;
    bus(1, `WDOG_LIM_OFFSET, 16'h0020);
    bus(1, `CMD_OFFSET, 16'h0008);
    bus(1, `IRQ_MASK_OFFSET, 16'h0001);
    bus(1, `CST_OFFSET, 16'h8080);
    bus(0, `CST_OFFSET, 16'h0000);
    check(got & 32'h0000_0040, 32'h0000_0000);
    wait_n(80);
    bus(0, `CST_OFFSET, 16'h0000);
    check(got & 32'h0000_0040, 32'h0000_0040);
    check(irq, 1'b1);
    bus(0, `IRQ_STAT_OFFSET, 16'h0000);
    check(got, 32'h0000_0001);
    bus(1, `CST_OFFSET, 16'h8000);
    bus(0, `CST_OFFSET, 16'h0000);
    check(got & 32'h0000_0040, 32'h0000_0000);
    check(irq, 1'b0);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_toggle();
    t_pulse();
    t_soft();
    t_wait_idle();
    t_wdog();
    final_report();
  end
endmodule
`default_nettype wire
